// *** hw/main_clock_unit.sv ***
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
// Summary of operation
// - Prescale field selects divide by 2,4,8,16.
// - Slow bit zero gives undivided core clock.
// - Clock-out bit drives oscillator clock / 2 to pin.
// - Timebase field selects 16k/32k/80k/200k cycles.
// - New timebase applies at end of period.
// - Flag set each time period elapses, except in active halt.
// - Register read clears flag, writes do not.
// - Interrupt needs enable and unmasked core.
// - Halt with enable set enters active halt.
// - Wait keeps running; tick wakes from wait.
// - Active halt: counter runs, registers frozen.
// - Full halt freezes counter and registers.
// - Tick wakes wait and active halt, not halt.
// - Reset loads register with zero.
// - Prescaler, clock-out, timebase work independently.
`include "main_clock_unit_regs.svh"

module main_clock_unit
	import main_clock_unit_pkg::*;
#(
	parameter int unsigned TB_P0 = 16000,
	parameter int unsigned TB_P1 = 32000,
	parameter int unsigned TB_P2 = 80000,
	parameter int unsigned TB_P3 = 200000
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	// AXI4-Lite slave
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Core side
	input wire logic halt_exec_i,
	input wire logic wait_exec_i,
	input wire logic halt_wakeup_i,
	input wire logic awu_halt_i,
	input wire logic core_irq_masked_i,
	output logic core_clk_en_o,
	output logic clock_out_o,
	output logic clock_out_oe_o,
	output logic tick_irq_o,
	output logic [1:0] power_state_o
);

	ccs_t ccs_q;
	power_state_t pwr_q;
	logic [17:0] tb_cnt_q;
	logic [1:0] tb_active_q;
	logic [3:0] div_cnt_q;
	logic aw_q, w_q;
	logic [11:0] awaddr_q;
	logic [7:0] wdata_q;
	logic wstrb0_q;

	logic regs_run, cnt_run, tb_end, rd_clear, wr_fire, rd_fire;
	logic [17:0] tb_limit;
	logic [3:0] div_mask;

	// ----------------------------------------
	// Power mode gating
	// ----------------------------------------
	assign regs_run = clk_en_i && (pwr_q == PWR_RUN || pwr_q == PWR_WAIT);
	assign cnt_run = clk_en_i && pwr_q != PWR_HALT;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pwr_q <= PWR_RUN;
		end else if (clk_en_i) begin
			unique case (pwr_q)
				PWR_RUN: begin
					if (halt_exec_i) begin
						pwr_q <= ccs_q.tick_irq_enable ? PWR_ACTIVE_HALT : PWR_HALT;
					end else if (wait_exec_i) begin
						pwr_q <= PWR_WAIT;
					end
				end
				PWR_WAIT: begin
					if (tick_irq_o || halt_wakeup_i) begin
						pwr_q <= PWR_RUN;
					end
				end
				PWR_ACTIVE_HALT: begin
					if (tb_end || halt_wakeup_i) begin
						pwr_q <= PWR_RUN;
					end
				end
				PWR_HALT: begin
					if (halt_wakeup_i) begin
						pwr_q <= PWR_RUN;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Timebase counter
	// ----------------------------------------
	always_comb begin
		unique case (tb_active_q)
			2'b00: tb_limit = 18'(TB_P0);
			2'b01: tb_limit = 18'(TB_P1);
			2'b10: tb_limit = 18'(TB_P2);
			2'b11: tb_limit = 18'(TB_P3);
		endcase
	end

	assign tb_end = cnt_run && tb_cnt_q == tb_limit - 18'd1;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			tb_cnt_q <= 18'd0;
			tb_active_q <= 2'b00;
		end else if (cnt_run) begin
			if (tb_end) begin
				tb_cnt_q <= 18'd0;
				tb_active_q <= ccs_q.timebase_select;
			end else begin
				tb_cnt_q <= tb_cnt_q + 18'd1;
			end
		end
	end

	// ----------------------------------------
	// Core clock prescaler and clock-out
	// ----------------------------------------
	always_comb begin
		unique case (ccs_q.core_prescale_sel)
			2'b00: div_mask = 4'h1;
			2'b01: div_mask = 4'h3;
			2'b10: div_mask = 4'h7;
			2'b11: div_mask = 4'hf;
		endcase
	end

	// Free-running divider so the prescaler never disturbs the timebase
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			div_cnt_q <= 4'h0;
			core_clk_en_o <= 1'b0;
		end else if (clk_en_i) begin
			div_cnt_q <= div_cnt_q + 4'h1;
			if (!ccs_q.slow_speed_select) begin
				core_clk_en_o <= 1'b1;
			end else begin
				core_clk_en_o <= (div_cnt_q & div_mask) == div_mask;
			end
		end
	end

	// Clock-out is a clk/2 square wave, the fastest one flop can make
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			clock_out_o <= 1'b0;
			clock_out_oe_o <= 1'b0;
		end else if (clk_en_i) begin
			clock_out_oe_o <= ccs_q.clock_out_select;
			clock_out_o <= ccs_q.clock_out_select & ~clock_out_o;
		end
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	assign wr_fire = aw_q && w_q && !s_axi_bvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign rd_clear = rd_fire && s_axi_araddr[11:2] == `CCS_ADDR >> 2;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q <= 8'h00;
			wstrb0_q <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else if (clk_en_i) begin
			s_axi_awready <= !aw_q && !s_axi_awready;
			s_axi_wready <= !w_q && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q <= 1'b1;
				wdata_q <= s_axi_wdata[7:0];
				wstrb0_q <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_q[11:2] == `CCS_ADDR >> 2 ||
					awaddr_q[11:2] == `MODE_ADDR >> 2) ? 2'b00 : 2'b10;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_q <= 1'b0;
				w_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else if (clk_en_i) begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !rd_fire;
			if (rd_fire) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				if (s_axi_araddr[11:2] == `CCS_ADDR >> 2) begin
					s_axi_rdata <= {24'h00_0000, ccs_q};
				end else if (s_axi_araddr[11:2] == `MODE_ADDR >> 2) begin
					s_axi_rdata <= {30'h0000_0000, pwr_q};
				end else begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'b10;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Control/status register
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ccs_q <= ccs_t'(`CCS_RESET);
		end else if (regs_run) begin
			if (wr_fire && wstrb0_q && awaddr_q[11:2] == `CCS_ADDR >> 2) begin
				ccs_q[7:1] <= wdata_q[7:1];
			end
			// Set wins over the read-clear
			if (tb_end) begin
				ccs_q.tick_irq_flag <= 1'b1;
			end else if (rd_clear) begin
				ccs_q.tick_irq_flag <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Interrupt request and mode status
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			tick_irq_o <= 1'b0;
			power_state_o <= 2'b00;
		end else if (clk_en_i) begin
			tick_irq_o <= ccs_q.tick_irq_flag && ccs_q.tick_irq_enable && !core_irq_masked_i;
			power_state_o <= pwr_q;
		end
	end

	// awu_halt_i: ignored; auto-wakeup halt enters active or full halt by tick_irq_enable, like any halt
	logic awu_unused;
	assign awu_unused = awu_halt_i;

endmodule

// *** hw/main_clock_unit_pkg.sv ***
package main_clock_unit_pkg;

	typedef enum logic [1:0] {
		PWR_RUN,
		PWR_WAIT,
		PWR_ACTIVE_HALT,
		PWR_HALT
	} power_state_t;

	typedef struct packed {
		logic clock_out_select;
		logic [1:0] core_prescale_sel;
		logic slow_speed_select;
		logic [1:0] timebase_select;
		logic tick_irq_enable;
		logic tick_irq_flag;
	} ccs_t;

endpackage

// *** hw/main_clock_unit_regs.svh ***
`ifndef MAIN_CLOCK_UNIT_REGS_SVH
`define MAIN_CLOCK_UNIT_REGS_SVH

// Register map; printed offset 0x2e is not a multiple of four, so it is an index
`define CCS_INDEX 8'h2e
`define CCS_ADDR 12'h0b8
`define CCS_RESET 8'h00
`define MODE_INDEX 8'h2f
`define MODE_ADDR 12'h0bc

// Field positions in clock_control_status
`define CCS_CLKOUT_BIT 7
`define CCS_PRESC_HI 6
`define CCS_PRESC_LO 5
`define CCS_SLOW_BIT 4
`define CCS_TB_HI 3
`define CCS_TB_LO 2
`define CCS_IRQEN_BIT 1
`define CCS_FLAG_BIT 0

// Timebase periods in oscillator cycles
`define TB_PERIOD_0 18'd16000
`define TB_PERIOD_1 18'd32000
`define TB_PERIOD_2 18'd80000
`define TB_PERIOD_3 18'd200000

`endif

// *** test/core_model.sv ***
`timescale 1ns/1ps
// Core side: counts the cycles it is clocked
module core_model (
	input wire logic clk_i,
	input wire logic core_clk_en_i,
	output logic [15:0] ticks_o
);
	initial ticks_o = 16'h0000;
	always @(posedge clk_i) begin
		if (core_clk_en_i) ticks_o <= ticks_o + 16'h0001;
	end
endmodule

// *** test/main_clock_unit_props.sv ***
`timescale 1ns/1ps
module main_clock_unit_props
	import main_clock_unit_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic halt_exec_i,
	input wire logic wait_exec_i,
	input wire logic halt_wakeup_i,
	input wire logic core_irq_masked_i,
	input wire logic core_clk_en_o,
	input wire logic clock_out_o,
	input wire logic clock_out_oe_o,
	input wire logic tick_irq_o,
	input wire logic [1:0] power_state_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	logic run;
	assign run = power_state_o == PWR_RUN;
	// Length of the current core clock gap; counted here because long repeats unroll badly
	logic [4:0] gap_q;
	always_ff @(posedge clk_i) begin
		if (reset_i || core_clk_en_o || !run) begin
			gap_q <= 5'h00;
		end else if (clk_en_i && gap_q != 5'h1f) begin
			gap_q <= gap_q + 5'h01;
		end
	end
	a_clkout_idle: assert property (!clock_out_oe_o |-> !clock_out_o)
		else $error("clock out active while disabled");
	a_clkout_toggles: assert property (clock_out_oe_o && $past(clock_out_oe_o)
		|-> clock_out_o != $past(clock_out_o)) else $error("clock out not toggling");
	a_slow_gap: assert property (gap_q < 5'h10)
		else $error("core clock gap too long");
	a_irq_masked: assert property ($past(core_irq_masked_i) |-> !tick_irq_o)
		else $error("interrupt while masked");
	a_reset_zero: assert property (disable iff (1'b0) reset_i |=> !tick_irq_o
		&& !clock_out_oe_o && run) else $error("outputs not cleared by reset");
	a_halt_enter: assert property (run && halt_exec_i |-> ##2
		power_state_o inside {PWR_ACTIVE_HALT, PWR_HALT}) else $error("halt not entered");
	a_wait_enter: assert property (run && wait_exec_i && !halt_exec_i && !tick_irq_o
		|-> ##2 power_state_o == PWR_WAIT) else $error("wait not entered");
	a_wait_wake: assert property (power_state_o == PWR_WAIT && tick_irq_o
		|-> ##[1:2] run) else $error("tick did not end wait");
	a_halt_stays: assert property (power_state_o == PWR_HALT && !halt_wakeup_i
		&& !$past(halt_wakeup_i)
		|=> power_state_o == PWR_HALT) else $error("left halt without wakeup");
	c_active: cover property (power_state_o == PWR_ACTIVE_HALT);
	c_wait: cover property (power_state_o == PWR_WAIT);
	c_tick: cover property (tick_irq_o);
endmodule
bind main_clock_unit main_clock_unit_props chk (.clk_i, .reset_i, .clk_en_i, .halt_exec_i,
	.wait_exec_i, .halt_wakeup_i, .core_irq_masked_i, .core_clk_en_o, .clock_out_o,
	.clock_out_oe_o, .tick_irq_o, .power_state_o);

// *** test/test_main_clock_unit.sv ***
`timescale 1ns/1ps
`include "main_clock_unit_regs.svh"
module test_main_clock_unit;
	import main_clock_unit_pkg::*;
	logic clk_i = 0, reset_i = 1, clk_en_i = 1, halt_exec_i = 0, wait_exec_i = 0;
	logic halt_wakeup_i = 0, awu_halt_i = 0, core_irq_masked_i = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, core_clk_en_o, clock_out_o, clock_out_oe_o, tick_irq_o;
	logic [1:0] s_axi_bresp, s_axi_rresp, power_state_o, r;
	logic [15:0] ticks, t0;
	logic [31:0] seed = 32'h4f6625ee;
	int fail_count = 0, num_checks = 0, cyc = 0, a, b;
	always #50 clk_i = ~clk_i;
	always @(posedge clk_i) cyc <= cyc + 1;
	main_clock_unit #(.TB_P0(16), .TB_P1(32), .TB_P2(80), .TB_P3(200)) DUT (.*);
	core_model partner (.clk_i, .core_clk_en_i(core_clk_en_o), .ticks_o(ticks));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	function automatic int period(input int s);
		return s == 0 ? 16 : s == 1 ? 32 : s == 2 ? 80 : 200;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] v);
		@(posedge clk_i);
		s_axi_awaddr <= `CCS_ADDR;
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge clk_i);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 0;
	endtask
	task automatic rd(input logic [11:0] ad);
		@(posedge clk_i);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge clk_i);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	task automatic rise(output int t);
		do @(posedge clk_i); while (tick_irq_o);
		do @(posedge clk_i); while (!tick_irq_o);
		t = cyc;
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		#1ms;
		fail_count++;
		results();
	end
	initial begin
		repeat (4) @(posedge clk_i);
		reset_i <= 0;
		repeat (2) @(posedge clk_i);
		rd(`CCS_ADDR);
		chk(d, 0);
		rd(12'h0c0);
		chk(r, 2'b10);
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			core_irq_masked_i <= seed[9];
			wr(seed[7:0]);
			rd(`CCS_ADDR);
			chk(d[7:1], seed[7:1]);
			chk(clock_out_oe_o, seed[7]);
		end
		core_irq_masked_i <= 0;
		for (int p = 0; p < 5; p++) begin
			wr(p < 4 ? {1'b1, p[1:0], 5'h10} : 8'h00);
			repeat (4) @(posedge clk_i);
			t0 = ticks;
			repeat (32) @(posedge clk_i);
			chk(ticks - t0, p < 4 ? 32 >> (p + 1) : 32);
		end
		for (int s = 3; s >= 0; s--) begin
			wr({4'hf, s[1:0], 2'b10});
			rd(`CCS_ADDR);
			rise(a);
			rd(`CCS_ADDR);
			chk(d[0], 1);
			rd(`CCS_ADDR);
			chk(d[0], 0);
			rise(b);
			chk(b - a, period(s));
		end
		rd(`CCS_ADDR);
		@(posedge clk_i) wait_exec_i <= 1;
		@(posedge clk_i) wait_exec_i <= 0;
		repeat (2) @(posedge clk_i);
		chk(power_state_o, PWR_WAIT);
		rise(a);
		repeat (3) @(posedge clk_i);
		chk(power_state_o, PWR_RUN);
		@(posedge clk_i) halt_exec_i <= 1;
		@(posedge clk_i) halt_exec_i <= 0;
		repeat (2) @(posedge clk_i);
		chk(power_state_o, PWR_ACTIVE_HALT);
		repeat (40) @(posedge clk_i);
		chk(power_state_o, PWR_RUN);
		wr(8'h00);
		@(posedge clk_i) halt_exec_i <= 1;
		@(posedge clk_i) halt_exec_i <= 0;
		repeat (60) @(posedge clk_i);
		chk(power_state_o, PWR_HALT);
		@(posedge clk_i) halt_wakeup_i <= 1;
		@(posedge clk_i) halt_wakeup_i <= 0;
		repeat (2) @(posedge clk_i);
		chk(power_state_o, PWR_RUN);
		results();
	end
endmodule
